// ### sat_acc_counter.sv
`timescale 1ns/1ps
`default_nettype none
module sat_acc_counter #(
    parameter int CW = 24
) (
    input  wire logic          i_clk,
    input  wire logic          i_nrst,
    input  wire logic          i_load,
    input  wire logic [CW-1:0] i_value,
    input  wire logic          i_tick,
    output logic               o_runout
);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          run_q;
    logic          run_d;

    // Counts memory cycles down; the runout pulse fires once on reaching zero.
    always_comb
    begin
        cnt_d = cnt_q;
        run_d = 1'b0;
        if (i_load)
        begin
            cnt_d = i_value;
        end
        else if (i_tick && cnt_q != '0)
        begin
            cnt_d = cnt_q - CW'(1);
            run_d = (cnt_q == CW'(1));
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt_q <= sat_pkg::ACC_RST[CW-1:0];
            run_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end

    assign o_runout = run_q;

endmodule : sat_acc_counter
`default_nettype wire

// ### sat_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sat_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_req,
    input  wire logic [23:0] i_addr,
    input  wire logic [1:0]  i_delay,
    output logic             o_ack,
    output logic [35:0]      o_rdata
);
    logic [35:0] mem [int];
    int          wait_cnt;

    initial
    begin
        o_ack    = 1'b0;
        o_rdata  = 36'h000000000;
        wait_cnt = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outside an answer cycle the data lines toggle so stale data is never mistaken.
    always @(negedge i_clk)
    begin
        o_ack   <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_nrst && i_req && !o_ack)
        begin
            if (wait_cnt >= int'(i_delay))
            begin
                o_ack    <= 1'b1;
                o_rdata  <= mem.exists(i_addr) ? mem[i_addr] : {12'hA5A, i_addr};
                wait_cnt <= 0;
            end
            else
            begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule : sat_mem_model
`default_nettype wire

// ### sat_pkg.sv
package sat_pkg;

    localparam int AW = 24;
    localparam int DW = 36;
    localparam int SW = 18;
    localparam int NV = 32;

    // Descriptor entry word layout.
    localparam int DESC_ORG_LSB   = 22;
    localparam int DESC_ORG_W     = 14;
    localparam int DESC_BND_LSB   = 4;
    localparam int DESC_VALID_BIT = 0;
    localparam int ORG_SHIFT      = 10;

    localparam logic [AW-1:0] FAULT_VEC_BASE = 24'h000000;
    localparam logic [AW-1:0] INTR_VEC_BASE  = 24'h000040;
    localparam logic [AW-1:0] DTB_ORG_RST    = 24'h000000;
    localparam logic [SW-1:0] DTB_BND_RST    = 18'h00000;
    localparam logic [23:0]   ACC_RST        = 24'h000000;

    typedef enum logic [4:0] {
        SAT_F_STARTUP, SAT_F_EXECUTE, SAT_F_TROUBLE, SAT_F_INCOMPLETE,
        SAT_F_LOCKUP, SAT_F_DIV_CHECK, SAT_F_OVERFLOW, SAT_F_PARITY,
        SAT_F_ILL_MEM_CMD, SAT_F_ILL_DESC, SAT_F_ILL_PROC, SAT_F_COMPAT_A,
        SAT_F_COMPAT_B, SAT_F_PRIV_ENTRY_1, SAT_F_PRIV_ENTRY_2, SAT_F_PRIV_ENTRY_3,
        SAT_F_PRIV_ENTRY_4, SAT_F_DERAIL, SAT_F_TAG_1, SAT_F_TAG_2,
        SAT_F_TAG_3, SAT_F_DIRECTED_0, SAT_F_DIRECTED_1, SAT_F_DIRECTED_2,
        SAT_F_DIRECTED_3, SAT_F_DIRECTED_4, SAT_F_DIRECTED_5, SAT_F_DIRECTED_6,
        SAT_F_DIRECTED_7, SAT_F_CONNECT, SAT_F_ACC_RUNOUT, SAT_F_SHUTDOWN
    } sat_fault_t;

    typedef enum logic [1:0] {
        SAT_S_IDLE,
        SAT_S_DESC,
        SAT_S_DATA
    } sat_state_t;

endpackage : sat_pkg

// ### sat_translate.sv
`timescale 1ns/1ps
`default_nettype none
module sat_translate (
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    input  wire logic                    i_priv,
    input  wire logic                    i_dtb_load,
    input  wire logic [sat_pkg::AW-1:0]  i_dtb_origin,
    input  wire logic [sat_pkg::SW-1:0]  i_dtb_bound,
    input  wire logic                    i_req,
    input  wire logic [sat_pkg::SW-1:0]  i_segno,
    input  wire logic [sat_pkg::SW-1:0]  i_segaddr,
    input  wire logic                    i_mem_ack,
    input  wire logic [sat_pkg::DW-1:0]  i_mem_rdata,
    input  wire logic [sat_pkg::NV-1:0]  i_fault,
    input  wire logic [sat_pkg::NV-1:0]  i_irq,
    input  wire logic                    i_self_irq,
    input  wire logic [4:0]              i_self_irq_num,
    input  wire logic                    i_acc_load,
    input  wire logic [23:0]             i_acc_value,
    output logic                         o_busy,
    output logic                         o_done,
    output logic [sat_pkg::DW-1:0]       o_rdata,
    output logic                         o_mem_req,
    output logic [sat_pkg::AW-1:0]       o_mem_addr,
    output logic                         o_trap,
    output logic                         o_trap_is_irq,
    output logic [4:0]                   o_trap_code,
    output logic [sat_pkg::AW-1:0]       o_trap_addr,
    output logic                         o_save_busy,
    output logic [sat_pkg::SW-1:0]       o_save_segno,
    output logic [sat_pkg::SW-1:0]       o_save_segaddr
);

    localparam int AW = sat_pkg::AW;
    localparam int SW = sat_pkg::SW;
    localparam int NV = sat_pkg::NV;

    // Lowest set bit wins: bit 5 flags a hit, bits 4:0 give its index.
    function automatic logic [5:0] first_set(input logic [NV-1:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int k = NV - 1; k >= 0; k--)
        begin
            if (v[k])
            begin
                r = {1'b1, 5'(k)};
            end
        end
        return r;
    endfunction : first_set

    ////////////////////////////////////////////////////////////////////////////////
    // Translation state.

    sat_pkg::sat_state_t   st_q, st_d;
    logic [AW-1:0]         dtb_org_q, dtb_org_d;
    logic [SW-1:0]         dtb_bnd_q, dtb_bnd_d;
    logic [SW-1:0]         seg_q, seg_d;
    logic [SW-1:0]         addr_q, addr_d;
    logic                  busy_q, busy_d;
    logic                  done_q, done_d;
    logic [sat_pkg::DW-1:0] rdata_q, rdata_d;
    logic                  mreq_q, mreq_d;
    logic [AW-1:0]         maddr_q, maddr_d;
    logic [NV-1:0]         int_fault;
    logic                  trap_take;
    logic                  acc_runout;
    logic [SW-1:0]         ent_bnd;
    logic [AW-1:0]         ent_org;

    assign ent_bnd = i_mem_rdata[sat_pkg::DESC_BND_LSB +: SW];
    assign ent_org = AW'(i_mem_rdata[sat_pkg::DESC_ORG_LSB +: sat_pkg::DESC_ORG_W])
                     << sat_pkg::ORG_SHIFT;

    always_comb
    begin
        st_d      = st_q;
        dtb_org_d = dtb_org_q;
        dtb_bnd_d = dtb_bnd_q;
        seg_d     = seg_q;
        addr_d    = addr_q;
        done_d    = 1'b0;
        rdata_d   = rdata_q;
        mreq_d    = mreq_q;
        maddr_d   = maddr_q;
        int_fault = '0;
        unique case (st_q)
            sat_pkg::SAT_S_IDLE:
            begin
                if (i_dtb_load)
                begin
                    if (i_priv)
                    begin
                        dtb_org_d = i_dtb_origin;
                        dtb_bnd_d = i_dtb_bound;
                    end
                    else
                    begin
                        int_fault[sat_pkg::SAT_F_ILL_PROC] = 1'b1;
                    end
                end
                else if (i_req)
                begin
                    seg_d  = i_segno;
                    addr_d = i_segaddr;
                    if (i_segno > dtb_bnd_q)
                    begin
                        int_fault[sat_pkg::SAT_F_ILL_DESC] = 1'b1;
                    end
                    else
                    begin
                        st_d    = sat_pkg::SAT_S_DESC;
                        mreq_d  = 1'b1;
                        maddr_d = dtb_org_q + AW'(i_segno);
                    end
                end
            end
            sat_pkg::SAT_S_DESC:
            begin
                if (i_mem_ack)
                begin
                    if (!i_mem_rdata[sat_pkg::DESC_VALID_BIT])
                    begin
                        int_fault[sat_pkg::SAT_F_ILL_DESC] = 1'b1;
                        st_d   = sat_pkg::SAT_S_IDLE;
                        mreq_d = 1'b0;
                    end
                    else if (addr_q > ent_bnd)
                    begin
                        int_fault[sat_pkg::SAT_F_ILL_MEM_CMD] = 1'b1;
                        st_d   = sat_pkg::SAT_S_IDLE;
                        mreq_d = 1'b0;
                    end
                    else
                    begin
                        st_d    = sat_pkg::SAT_S_DATA;
                        maddr_d = ent_org + AW'(addr_q);
                    end
                end
            end
            sat_pkg::SAT_S_DATA:
            begin
                if (i_mem_ack)
                begin
                    rdata_d = i_mem_rdata;
                    done_d  = 1'b1;
                    mreq_d  = 1'b0;
                    st_d    = sat_pkg::SAT_S_IDLE;
                end
            end
            default:
            begin
                st_d = sat_pkg::SAT_S_IDLE;
            end
        endcase
        if (trap_take)
        begin
            st_d   = sat_pkg::SAT_S_IDLE;
            mreq_d = 1'b0;
            done_d = 1'b0;
        end
        busy_d = (st_d != sat_pkg::SAT_S_IDLE);
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q      <= sat_pkg::SAT_S_IDLE;
            dtb_org_q <= sat_pkg::DTB_ORG_RST;
            dtb_bnd_q <= sat_pkg::DTB_BND_RST;
            seg_q     <= '0;
            addr_q    <= '0;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            rdata_q   <= '0;
            mreq_q    <= 1'b0;
            maddr_q   <= '0;
        end
        else
        begin
            st_q      <= st_d;
            dtb_org_q <= dtb_org_d;
            dtb_bnd_q <= dtb_bnd_d;
            seg_q     <= seg_d;
            addr_q    <= addr_d;
            busy_q    <= busy_d;
            done_q    <= done_d;
            rdata_q   <= rdata_d;
            mreq_q    <= mreq_d;
            maddr_q   <= maddr_d;
        end
    end

    sat_acc_counter #(
        .CW (24)
    ) u_acc (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_load   (i_acc_load),
        .i_value  (i_acc_value),
        .i_tick   (mreq_q && i_mem_ack),
        .o_runout (acc_runout)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Fault and interrupt dispatch.

    logic [NV-1:0] fpend_q, fpend_d, fset;
    logic [NV-1:0] ipend_q, ipend_d, iset;
    logic [5:0]    fsel, isel;
    logic          trap_q, trap_d;
    logic          tirq_q, tirq_d;
    logic [4:0]    tcode_q, tcode_d;
    logic [AW-1:0] taddr_q, taddr_d;
    logic          sbusy_q, sbusy_d;
    logic [SW-1:0] sseg_q, sseg_d;
    logic [SW-1:0] saddr_q, saddr_d;

    assign fsel      = first_set(fpend_q);
    assign isel      = first_set(ipend_q);
    assign trap_take = fsel[5] || isel[5];

    always_comb
    begin
        fset = i_fault | int_fault;
        fset[sat_pkg::SAT_F_ACC_RUNOUT] = fset[sat_pkg::SAT_F_ACC_RUNOUT] | acc_runout;
        iset = i_irq | ({{(NV-1){1'b0}}, i_self_irq} << i_self_irq_num);
        fpend_d = fpend_q | fset;
        ipend_d = ipend_q | iset;
        trap_d  = 1'b0;
        tirq_d  = tirq_q;
        tcode_d = tcode_q;
        taddr_d = taddr_q;
        sbusy_d = sbusy_q;
        sseg_d  = sseg_q;
        saddr_d = saddr_q;
        if (trap_take)
        begin
            trap_d  = 1'b1;
            sbusy_d = busy_q;
            sseg_d  = seg_q;
            saddr_d = addr_q;
            if (fsel[5])
            begin
                fpend_d[fsel[4:0]] = fset[fsel[4:0]];
                tirq_d  = 1'b0;
                tcode_d = fsel[4:0];
                taddr_d = sat_pkg::FAULT_VEC_BASE + AW'({fsel[4:0], 1'b0});
            end
            else
            begin
                ipend_d[isel[4:0]] = iset[isel[4:0]];
                tirq_d  = 1'b1;
                tcode_d = isel[4:0];
                taddr_d = sat_pkg::INTR_VEC_BASE + AW'({isel[4:0], 1'b0});
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            fpend_q <= '0;
            ipend_q <= '0;
            trap_q  <= 1'b0;
            tirq_q  <= 1'b0;
            tcode_q <= '0;
            taddr_q <= '0;
            sbusy_q <= 1'b0;
            sseg_q  <= '0;
            saddr_q <= '0;
        end
        else
        begin
            fpend_q <= fpend_d;
            ipend_q <= ipend_d;
            trap_q  <= trap_d;
            tirq_q  <= tirq_d;
            tcode_q <= tcode_d;
            taddr_q <= taddr_d;
            sbusy_q <= sbusy_d;
            sseg_q  <= sseg_d;
            saddr_q <= saddr_d;
        end
    end

    assign o_busy         = busy_q;
    assign o_done         = done_q;
    assign o_rdata        = rdata_q;
    assign o_mem_req      = mreq_q;
    assign o_mem_addr     = maddr_q;
    assign o_trap         = trap_q;
    assign o_trap_is_irq  = tirq_q;
    assign o_trap_code    = tcode_q;
    assign o_trap_addr    = taddr_q;
    assign o_save_busy    = sbusy_q;
    assign o_save_segno   = sseg_q;
    assign o_save_segaddr = saddr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_DTB_LOAD: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st_q == sat_pkg::SAT_S_IDLE && i_dtb_load && i_priv)
        |=> (dtb_org_q == $past(i_dtb_origin) && dtb_bnd_q == $past(i_dtb_bound)))
        else $error("Base register did not take the privileged load.");

    AST_DTB_PRIV: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st_q == sat_pkg::SAT_S_IDLE && i_dtb_load && !i_priv)
        |=> ($stable(dtb_org_q) && fpend_q[sat_pkg::SAT_F_ILL_PROC]))
        else $error("Unprivileged base load was not refused.");

    AST_DESC_INDEX: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st_q == sat_pkg::SAT_S_DESC && mreq_q)
        |-> (maddr_q == dtb_org_q + AW'(seg_q)))
        else $error("Descriptor fetch address is wrong.");

    AST_ABS_ADDR: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st_q == sat_pkg::SAT_S_DESC && i_mem_ack && !trap_take
         && i_mem_rdata[sat_pkg::DESC_VALID_BIT] && addr_q <= ent_bnd)
        |=> (st_q == sat_pkg::SAT_S_DATA && maddr_q == $past(ent_org) + AW'($past(addr_q))))
        else $error("Absolute address is not origin plus segment address.");

    AST_BOUND: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st_q == sat_pkg::SAT_S_DESC && i_mem_ack
         && i_mem_rdata[sat_pkg::DESC_VALID_BIT] && addr_q > ent_bnd)
        |=> (!mreq_q && !done_q && fpend_q[sat_pkg::SAT_F_ILL_MEM_CMD]))
        else $error("Out-of-range reference was not suppressed.");

    AST_SEGNO_LIMIT: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (st_q == sat_pkg::SAT_S_IDLE && i_req && !i_dtb_load && i_segno > dtb_bnd_q)
        |=> (st_q == sat_pkg::SAT_S_IDLE && !mreq_q))
        else $error("Segment number beyond the table was accepted.");

    AST_VECTOR: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_trap |-> (o_trap_addr == (o_trap_is_irq ? sat_pkg::INTR_VEC_BASE
                                                  : sat_pkg::FAULT_VEC_BASE)
                                   + AW'({o_trap_code, 1'b0})))
        else $error("Trap vector address does not match its code.");

    AST_ABANDON: assert property (@(posedge i_clk) disable iff (!i_nrst)
        trap_take |=> (o_trap && st_q == sat_pkg::SAT_S_IDLE && !mreq_q && !done_q))
        else $error("Dispatch did not abandon the reference.");

    AST_FAULT_SEEN: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_fault != '0) |-> ##[1:70] (o_trap && !o_trap_is_irq))
        else $error("Fault was never dispatched.");

    AST_RUNOUT: assert property (@(posedge i_clk) disable iff (!i_nrst)
        acc_runout |=> fpend_q[sat_pkg::SAT_F_ACC_RUNOUT])
        else $error("Counter runout did not raise its fault.");

    AST_SAVE: assert property (@(posedge i_clk) disable iff (!i_nrst)
        trap_take |=> (o_save_segno == $past(seg_q) && o_save_segaddr == $past(addr_q)
                       && o_save_busy == $past(busy_q)))
        else $error("Dispatch did not save the reference state.");

endmodule : sat_translate
`default_nettype wire

// ### segment_address_translation_test.sv
`timescale 1ns/1ps
`default_nettype none
module segment_address_translation_test;
    logic        i_clk = 1'b0;
    logic        i_nrst, i_priv, i_dtb_load, i_req, i_mem_ack, i_self_irq, i_acc_load;
    logic [23:0] i_dtb_origin, i_acc_value, o_mem_addr, o_trap_addr, m_org;
    logic [17:0] i_dtb_bound, i_segno, i_segaddr, o_save_segno, o_save_segaddr, m_bnd;
    logic [35:0] i_mem_rdata, o_rdata;
    logic [31:0] i_fault, i_irq, seed, irq_set;
    logic [4:0]  i_self_irq_num, o_trap_code;
    logic [1:0]  mdelay;
    logic        o_busy, o_done, o_mem_req, o_trap, o_trap_is_irq, o_save_busy;
    logic [35:0] img [int];
    logic [35:0] cases [8];
    int          num_errors = 0;
    int          samples_checked = 0;

    sat_translate sat_translate_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_priv(i_priv),
        .i_dtb_load(i_dtb_load), .i_dtb_origin(i_dtb_origin), .i_dtb_bound(i_dtb_bound),
        .i_req(i_req), .i_segno(i_segno), .i_segaddr(i_segaddr), .i_mem_ack(i_mem_ack),
        .i_mem_rdata(i_mem_rdata), .i_fault(i_fault), .i_irq(i_irq), .i_self_irq(i_self_irq),
        .i_self_irq_num(i_self_irq_num), .i_acc_load(i_acc_load), .i_acc_value(i_acc_value),
        .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_mem_req(o_mem_req),
        .o_mem_addr(o_mem_addr), .o_trap(o_trap), .o_trap_is_irq(o_trap_is_irq),
        .o_trap_code(o_trap_code), .o_trap_addr(o_trap_addr), .o_save_busy(o_save_busy),
        .o_save_segno(o_save_segno), .o_save_segaddr(o_save_segaddr));

    sat_mem_model sat_mem_model_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(o_mem_req),
        .i_addr(o_mem_addr), .i_delay(mdelay), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

    always #5 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic put(input logic [23:0] a, input logic [35:0] d);
        img[a] = d;
        sat_mem_model_i.mem[a] = d;
    endtask : put

    task automatic wait_trap(input logic irq, input logic [4:0] code);
        for (int k = 0; k < 40; k++)
        begin
            @(negedge i_clk);
            if (o_done === 1'b1)
                check(o_done, 1'b0);
            if (o_trap === 1'b1)
                break;
        end
        check(o_trap, 1'b1);
        check(o_trap_is_irq, irq);
        check(o_trap_code, code);
        check(o_trap_addr, (irq ? sat_pkg::INTR_VEC_BASE : sat_pkg::FAULT_VEC_BASE) + 2 * code);
    endtask : wait_trap

    task automatic load(input logic p, input logic [23:0] org, input logic [17:0] bnd);
        @(negedge i_clk);
        i_priv       = p;
        i_dtb_load   = 1'b1;
        i_dtb_origin = org;
        i_dtb_bound  = bnd;
        @(negedge i_clk);
        i_dtb_load = 1'b0;
        if (p)
        begin
            m_org = org;
            m_bnd = bnd;
        end
        else
            wait_trap(1'b0, 5'h0A);
    endtask : load

    // The model decides the outcome before the request goes out.
    task automatic xlate(input logic [17:0] sn, input logic [17:0] sa);
        logic [35:0] e;
        logic [35:0] d;
        logic [23:0] da;
        int          code;
        code = -1;
        d    = {rnd(), 4'h0};
        if (sn > m_bnd)
            code = 9;
        else
        begin
            e = img[m_org + 24'(sn)];
            if (e[0] == 1'b0)
                code = 9;
            else if (sa > e[21:4])
                code = 8;
            else
            begin
                da = {e[35:22], 10'h000} + 24'(sa);
                put(da, d);
            end
        end
        mdelay = 2'(rnd());
        @(negedge i_clk);
        i_req     = 1'b1;
        i_segno   = sn;
        i_segaddr = sa;
        @(negedge i_clk);
        i_req = 1'b0;
        if (sn <= m_bnd)
            check(o_mem_addr, m_org + 24'(sn));
        if (code < 0)
        begin
            for (int k = 0; k < 100 && o_done !== 1'b1 && o_trap !== 1'b1; k++)
                @(negedge i_clk);
            check(o_done, 1'b1);
            check(o_rdata, d);
            check(o_mem_addr, da);
            @(negedge i_clk);
            check(o_busy, 1'b0);
        end
        else
        begin
            wait_trap(1'b0, 5'(code));
            check(o_save_segno, sn);
            check(o_save_segaddr, sa);
            check(o_save_busy, 1'b0);
        end
    endtask : xlate

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #300us;
        num_errors++;
        finish_test();
    end

    initial
    begin
        {i_nrst, i_priv, i_dtb_load, i_req, i_self_irq, i_acc_load} = 6'h00;
        {i_dtb_origin, i_acc_value, i_dtb_bound, i_segno, i_segaddr} = 102'h0;
        {i_fault, i_irq, i_self_irq_num, mdelay} = 71'h0;
        seed = 32'hEF5A;
        repeat (10) @(negedge i_clk);
        i_nrst = 1'b1;
        load(1'b1, 24'h001000, 18'h00003);
        put(24'h001000, {14'h0001, 18'h3FFFF, 4'h1});
        put(24'h001001, {14'h0002, 18'h00000, 4'h1});
        put(24'h001002, {14'h0003, 18'h00005, 4'h0});
        put(24'h001003, {14'h3FFF, 18'h00010, 4'h1});
        cases = '{{18'h0, 18'h3FFFF}, {18'h1, 18'h0}, {18'h1, 18'h1}, {18'h2, 18'h0},
                  {18'h3, 18'h10}, {18'h3, 18'h11}, {18'h4, 18'h0}, {18'h3FFFF, 18'h0}};
        foreach (cases[i])
            xlate(cases[i][35:18], cases[i][17:0]);
        repeat (12)
            xlate(18'(rnd() % 5), 18'(rnd()) & 18'h0001F);
        load(1'b0, 24'h002000, 18'h00000);
        xlate(18'h1, 18'h0);
        load(1'b1, 24'h002000, 18'h3FFFF);
        put(24'h002000, {14'h0005, 18'h00007, 4'h1});
        put(24'h041FFF, {14'h0006, 18'h00002, 4'h1});
        xlate(18'h0, 18'h7);
        xlate(18'h0, 18'h8);
        xlate(18'h3FFFF, 18'h2);
        @(negedge i_clk);
        i_acc_load  = 1'b1;
        i_acc_value = 24'h000002;
        @(negedge i_clk);
        i_acc_load = 1'b0;
        xlate(18'h0, 18'h3);
        wait_trap(1'b0, 5'h1E);
        // A fault during a slow descriptor fetch must abandon the reference.
        mdelay = 2'h3;
        @(negedge i_clk);
        i_req     = 1'b1;
        i_segno   = 18'h00000;
        i_segaddr = 18'h00001;
        @(negedge i_clk);
        i_req   = 1'b0;
        i_fault = 32'h00000004;
        @(negedge i_clk);
        i_fault = 32'h00000000;
        wait_trap(1'b0, 5'h02);
        check(o_save_busy, 1'b1);
        check(o_save_segno, 18'h00000);
        check(o_save_segaddr, 18'h00001);
        check(o_busy, 1'b0);
        check(o_mem_req, 1'b0);
        @(negedge i_clk);
        i_fault        = 32'hFFFFFFFF;
        i_irq          = rnd();
        i_self_irq     = 1'b1;
        i_self_irq_num = 5'h03;
        irq_set        = i_irq | 32'h00000008;
        @(negedge i_clk);
        i_fault    = 32'h00000000;
        i_irq      = 32'h00000000;
        i_self_irq = 1'b0;
        for (int c = 0; c < 32; c++)
            wait_trap(1'b0, 5'(c));
        for (int c = 0; c < 32; c++)
            if (irq_set[c])
                wait_trap(1'b1, 5'(c));
        finish_test();
    end
endmodule : segment_address_translation_test
`default_nettype wire
